// [common/fcx_pkg.sv]
// Constants for the fault flag, interrupt mask and monitor conversion control block.
// Assumes byte-wide registers reached by the serial interface's register access port.
package fcx_pkg;
    localparam logic [7:0] FCX_OFS_FLAGS_B = 8'h0F;
    localparam logic [7:0] FCX_OFS_MASK_B  = 8'h10;
    localparam logic [7:0] FCX_OFS_FLAGS_C = 8'h11;
    localparam logic [7:0] FCX_OFS_MASK_C  = 8'h12;
    localparam logic [7:0] FCX_OFS_CTRL    = 8'h13;

    localparam logic [7:0] FCX_RST_FLAGS   = 8'h00;
    localparam logic [7:0] FCX_RST_MASK    = 8'h00;
    localparam logic [7:0] FCX_RST_CTRL    = 8'h00;
    localparam logic [7:0] FCX_RD_UNMAPPED = 8'h00;

    // Flags B bit positions
    localparam int FCX_B_BATT_OV   = 7;
    localparam int FCX_B_BATT_OC   = 6;
    localparam int FCX_B_VREG      = 5;
    localparam int FCX_B_IREG      = 4;
    localparam int FCX_B_DIE_OT    = 3;
    localparam int FCX_B_RATIO_LO  = 2;
    localparam int FCX_B_RATIO_HI  = 1;
    localparam int FCX_B_PEAK      = 0;
    // Flags C bit positions
    localparam int FCX_C_IN_ARRIVE = 7;
    localparam int FCX_C_BAT_ARRIV = 6;
    localparam int FCX_C_WDOG      = 5;
    localparam int FCX_C_AD_MISS   = 4;
    localparam int FCX_C_IN_MISS   = 3;
    localparam int FCX_C_OUT_OV    = 2;
    localparam int FCX_C_ADC_DONE  = 1;
    localparam int FCX_C_PIN_SHORT = 0;
    // Control bit positions
    localparam int FCX_CTRL_RUN    = 7;
    localparam int FCX_CTRL_ONESHOT = 6;

    // Channel order in the sequence; channel i is disabled by control bit 5-i
    localparam int            FCX_NUM_CHAN   = 6;
    localparam logic [2:0]    FCX_CH_IN_CURR = 3'h1;
    localparam logic [2:0]    FCX_CH_BT_CURR = 3'h3;
    localparam logic [2:0]    FCX_CH_LAST    = 3'h5;
    localparam logic [2:0]    FCX_CHG_OFF    = 3'h0;

    typedef enum logic [1:0] {FCX_SEQ_IDLE, FCX_SEQ_SCAN, FCX_SEQ_WAIT} fcx_seq_e;
endpackage : fcx_pkg

// [rtl/fcx_fault_flags.sv]
// Fault/event flags, interrupt masks, interrupt pin and monitor conversion sequencer.
// Assumes the serial slave presents one-cycle byte read/write strobes with an address,
// and that all condition inputs are synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module fcx_fault_flags
    import fcx_pkg::*;
#(
    parameter int RATIO_W   = 8,
    parameter int NUM_SWITCH = 4
)(
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  reg_reset,
    input  wire logic [7:0]            reg_addr,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  batt_ov_cond,
    input  wire logic                  batt_oc_evt,
    input  wire logic                  vbat_regulating,
    input  wire logic                  ibat_regulating,
    input  wire logic                  die_ot_cond,
    input  wire logic                  out_ov_cond,
    input  wire logic                  bypass_mode,
    input  wire logic [RATIO_W-1:0]    input_ratio,
    input  wire logic [RATIO_W-1:0]    input_ratio_low_limit,
    input  wire logic [RATIO_W-1:0]    input_ratio_high_limit,
    input  wire logic [NUM_SWITCH-1:0] switch_peak_hit,
    input  wire logic                  input_present,
    input  wire logic                  adapter_present,
    input  wire logic                  battery_present,
    input  wire logic                  host_watchdog_expired,
    input  wire logic                  switching_enabled,
    input  wire logic                  pin_short_detect,
    input  wire logic [2:0]            charge_operation_sel,
    input  wire logic                  adc_chan_done,
    output logic                       adc_start,
    output logic      [2:0]            adc_chan,
    output logic                       host_irq_n
);

    logic [7:0] flags_b_reg;
    logic [7:0] flags_c_reg;
    logic [7:0] fault_mask_b_reg;
    logic [7:0] fault_mask_c_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] rdata_reg;
    logic       irq_n_reg;
    logic       start_reg;
    logic [2:0] chan_reg;
    fcx_seq_e   seq_reg;
    logic [2:0] idx_reg;

    logic       run;
    logic       oneshot;
    logic       rd_b;
    logic       rd_c;
    logic       ratio_low;
    logic       ratio_high;
    logic       idx_en;
    logic       pass_end;
    logic       oneshot_done;
    logic [7:0] set_b;
    logic [7:0] set_c;

    // Channel i is converted when its disable bit is 0 and charging does not exclude it
    function automatic logic chan_enabled(input logic [7:0] ctrl, input logic [2:0] chg,
                                          input logic [2:0] idx);
        logic dis;
        dis = ctrl[3'd5 - idx];
        if (chg == FCX_CHG_OFF && (idx == FCX_CH_IN_CURR || idx == FCX_CH_BT_CURR))
            dis = 1'b1;
        return !dis && (idx <= FCX_CH_LAST);
    endfunction : chan_enabled

    assign run     = ctrl_reg[FCX_CTRL_RUN];
    assign oneshot = ctrl_reg[FCX_CTRL_ONESHOT];
    assign rd_b    = reg_rd && reg_addr == FCX_OFS_FLAGS_B;
    assign rd_c    = reg_rd && reg_addr == FCX_OFS_FLAGS_C;

    // Divider mode doubles the limit; one extra bit keeps the product exact
    assign ratio_low  = bypass_mode ? (input_ratio < input_ratio_low_limit)
                      : ({1'b0, input_ratio} < {input_ratio_low_limit, 1'b0});
    assign ratio_high = bypass_mode ? (input_ratio > input_ratio_high_limit)
                      : ({1'b0, input_ratio} > {input_ratio_high_limit, 1'b0});

    assign idx_en   = chan_enabled(ctrl_reg, charge_operation_sel, idx_reg);
    assign pass_end = run && ((seq_reg == FCX_SEQ_SCAN && !idx_en && idx_reg == FCX_CH_LAST)
                   || (seq_reg == FCX_SEQ_WAIT && adc_chan_done && idx_reg == FCX_CH_LAST));
    assign oneshot_done = pass_end && oneshot;

    // Level conditions set every cycle they hold, so a clearing read cannot win over them
    always_comb
    begin
        set_b = 8'h00;
        set_b[FCX_B_BATT_OV]  = batt_ov_cond;
        set_b[FCX_B_BATT_OC]  = batt_oc_evt;
        set_b[FCX_B_VREG]     = vbat_regulating;
        set_b[FCX_B_IREG]     = ibat_regulating;
        set_b[FCX_B_DIE_OT]   = die_ot_cond;
        set_b[FCX_B_RATIO_LO] = ratio_low;
        set_b[FCX_B_RATIO_HI] = ratio_high;
        set_b[FCX_B_PEAK]     = |switch_peak_hit;
        set_c = 8'h00;
        set_c[FCX_C_IN_ARRIVE] = input_present;
        set_c[FCX_C_BAT_ARRIV] = battery_present
                               && (run || adapter_present || input_present);
        set_c[FCX_C_WDOG]      = host_watchdog_expired;
        set_c[FCX_C_AD_MISS]   = !adapter_present;
        set_c[FCX_C_IN_MISS]   = !input_present;
        set_c[FCX_C_OUT_OV]    = out_ov_cond;
        set_c[FCX_C_ADC_DONE]  = oneshot_done;
        set_c[FCX_C_PIN_SHORT] = switching_enabled && pin_short_detect;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            flags_b_reg <= FCX_RST_FLAGS;
            flags_c_reg <= FCX_RST_FLAGS;
        end
        else
        begin
            // Set wins over the read that clears in the same cycle
            flags_b_reg <= set_b | (flags_b_reg & ~{8{rd_b}});
            flags_c_reg <= set_c | (flags_c_reg & ~{8{rd_c}})
                         & ~(reg_reset ? (8'h01 << FCX_C_WDOG) : 8'h00);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst || reg_reset)
        begin
            fault_mask_b_reg <= FCX_RST_MASK;
            fault_mask_c_reg <= FCX_RST_MASK;
        end
        else if (reg_wr)
        begin
            if (reg_addr == FCX_OFS_MASK_B)
                fault_mask_b_reg <= reg_wdata;
            if (reg_addr == FCX_OFS_MASK_C)
                fault_mask_c_reg <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst || reg_reset)
            ctrl_reg <= FCX_RST_CTRL;
        else
        begin
            if (reg_wr && reg_addr == FCX_OFS_CTRL)
                ctrl_reg <= reg_wdata;
            if (host_watchdog_expired || oneshot_done)
                ctrl_reg[FCX_CTRL_RUN] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            rdata_reg <= FCX_RD_UNMAPPED;
        else if (reg_rd)
        begin
            case (reg_addr)
                FCX_OFS_FLAGS_B: rdata_reg <= flags_b_reg;
                FCX_OFS_MASK_B:  rdata_reg <= fault_mask_b_reg;
                FCX_OFS_FLAGS_C: rdata_reg <= flags_c_reg;
                FCX_OFS_MASK_C:  rdata_reg <= fault_mask_c_reg;
                FCX_OFS_CTRL:    rdata_reg <= ctrl_reg;
                default:         rdata_reg <= FCX_RD_UNMAPPED;
            endcase
        end
    end

    // Level output; one cycle behind the flags so the pin comes from a flop
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            irq_n_reg <= 1'b1;
        else
            irq_n_reg <= !(|(flags_b_reg & ~fault_mask_b_reg)
                        || |(flags_c_reg & ~fault_mask_c_reg));
    end

    // Sequencer walks channels 0..5, waiting for each enabled one to convert and skipping disabled ones one per cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            seq_reg   <= FCX_SEQ_IDLE;
            idx_reg   <= 3'h0;
            start_reg <= 1'b0;
            chan_reg  <= 3'h0;
        end
        else
        begin
            start_reg <= 1'b0;
            case (seq_reg)
                FCX_SEQ_IDLE:
                begin
                    idx_reg <= 3'h0;
                    if (run)
                        seq_reg <= FCX_SEQ_SCAN;
                end
                FCX_SEQ_SCAN:
                begin
                    if (!run)
                        seq_reg <= FCX_SEQ_IDLE;
                    else if (idx_en)
                    begin
                        start_reg <= 1'b1;
                        chan_reg  <= idx_reg;
                        seq_reg   <= FCX_SEQ_WAIT;
                    end
                    else if (pass_end)
                    begin
                        idx_reg <= 3'h0;
                        seq_reg <= oneshot ? FCX_SEQ_IDLE : FCX_SEQ_SCAN;
                    end
                    else
                        idx_reg <= idx_reg + 3'h1;
                end
                FCX_SEQ_WAIT:
                begin
                    // A conversion in flight finishes even if run drops
                    if (adc_chan_done)
                    begin
                        if (pass_end)
                        begin
                            idx_reg <= 3'h0;
                            seq_reg <= oneshot ? FCX_SEQ_IDLE : FCX_SEQ_SCAN;
                        end
                        else
                        begin
                            idx_reg <= (idx_reg == FCX_CH_LAST) ? 3'h0 : idx_reg + 3'h1;
                            seq_reg <= run ? FCX_SEQ_SCAN : FCX_SEQ_IDLE;
                        end
                    end
                end
                default: seq_reg <= FCX_SEQ_IDLE;
            endcase
        end
    end

    assign reg_rdata  = rdata_reg;
    assign host_irq_n = irq_n_reg;
    assign adc_start  = start_reg;
    assign adc_chan   = chan_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_read_b_quiet;
        rd_b && !batt_oc_evt;
    endsequence

    a_level_hold_read: assert property (rd_b && batt_ov_cond |=> flags_b_reg[FCX_B_BATT_OV])
        else $error("over-voltage flag cleared while fault present");
    a_event_read_clear: assert property (s_read_b_quiet |=> !flags_b_reg[FCX_B_BATT_OC])
        else $error("over-current flag survived a read");
    a_regulation_set: assert property (ibat_regulating |=> flags_b_reg[FCX_B_IREG])
        else $error("current regulation flag not set");
    a_ratio_low_div: assert property (!bypass_mode && ({1'b0, input_ratio}
        < {input_ratio_low_limit, 1'b0}) |=> flags_b_reg[FCX_B_RATIO_LO])
        else $error("ratio low flag missed in divider mode");
    a_ratio_high_byp: assert property (bypass_mode && input_ratio > input_ratio_high_limit
        |=> flags_b_reg[FCX_B_RATIO_HI])
        else $error("ratio high flag missed in bypass mode");
    a_peak_or: assert property (|switch_peak_hit |=> flags_b_reg[FCX_B_PEAK])
        else $error("peak flag missed");
    a_mask_quiet_pin: assert property ((flags_b_reg & ~fault_mask_b_reg) == 8'h00
        && (flags_c_reg & ~fault_mask_c_reg) == 8'h00 |=> host_irq_n)
        else $error("interrupt raised with all flags masked or clear");
    a_unmasked_irq: assert property (flags_c_reg[FCX_C_PIN_SHORT]
        && !fault_mask_c_reg[FCX_C_PIN_SHORT] |=> !host_irq_n)
        else $error("unmasked flag did not drive interrupt");
    a_arrival_gate: assert property (!flags_c_reg[FCX_C_BAT_ARRIV] && !run && !adapter_present
        && !input_present |=> !flags_c_reg[FCX_C_BAT_ARRIV])
        else $error("battery arrival set without qualifier");
    a_missing_hold: assert property (rd_c && !adapter_present
        |=> flags_c_reg[FCX_C_AD_MISS] [*1] ##1 1'b1)
        else $error("adapter missing flag cleared while absent");
    a_oneshot_done: assert property (oneshot_done |=> flags_c_reg[FCX_C_ADC_DONE]
        && !run && seq_reg == FCX_SEQ_IDLE)
        else $error("single-shot completion not reported");
    a_pin_short_set: assert property (switching_enabled && pin_short_detect
        |=> flags_c_reg[FCX_C_PIN_SHORT] ##1 !host_irq_n || fault_mask_c_reg[FCX_C_PIN_SHORT])
        else $error("pin short not flagged");
    a_wdog_stops_run: assert property (host_watchdog_expired |=> !run)
        else $error("run bit survived watchdog expiry");
    a_skip_disabled: assert property (adc_start |-> chan_enabled(ctrl_reg,
        charge_operation_sel, adc_chan) || $past(reg_wr))
        else $error("disabled channel started");
endmodule : fcx_fault_flags
`default_nettype wire

// [testbench/fcx_adc_model.sv]
// Behavioural monitor converter that answers the sequencer's start pulses.
// Assumes one start at a time; answers alternate between fast and slow.
`timescale 1ns/1ns
`default_nettype none
module fcx_adc_model (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        adc_start,
    input  wire logic [2:0]  adc_chan,
    input  wire logic        hist_clr,
    output logic             adc_chan_done,
    output logic      [23:0] chan_hist,
    output logic      [3:0]  start_cnt
);
    logic [3:0] wait_cnt;
    logic       busy;
    logic       slow;

    always_ff @(posedge core_clk)
    begin
        adc_chan_done <= 1'b0;
        if (!nrst)
        begin
            busy <= 1'b0;
            slow <= 1'b0;
        end
        else if (adc_start)
        begin
            busy     <= 1'b1;
            wait_cnt <= slow ? 4'h5 : 4'h0;
            slow     <= ~slow;
        end
        else if (busy && wait_cnt == 4'h0)
        begin
            busy          <= 1'b0;
            adc_chan_done <= 1'b1;
        end
        else if (busy)
            wait_cnt <= wait_cnt - 4'h1;
    end

    // Log of started channels, newest in the low nibble
    always_ff @(posedge core_clk)
    begin
        if (!nrst || hist_clr)
        begin
            chan_hist <= 24'h000000;
            start_cnt <= 4'h0;
        end
        else if (adc_start)
        begin
            chan_hist <= {chan_hist[19:0], 1'b0, adc_chan};
            start_cnt <= start_cnt + 4'h1;
        end
    end
endmodule : fcx_adc_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the fault flag and monitor control block.
// Assumes the design answers reads one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import fcx_pkg::*;
    logic        core_clk, nrst, reg_reset, reg_wr, reg_rd, hist_clr;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, input_ratio, lo_lim, hi_lim;
    logic        batt_ov_cond, batt_oc_evt, vbat_regulating, ibat_regulating;
    logic        die_ot_cond, out_ov_cond, bypass_mode, input_present;
    logic        adapter_present, battery_present, wdog, switching_enabled;
    logic        pin_short_detect, adc_chan_done, adc_start, host_irq_n;
    logic [3:0]  switch_peak_hit, start_cnt;
    logic [2:0]  charge_operation_sel, adc_chan;
    logic [23:0] chan_hist;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [7:0]  lv_addr [5] = '{FCX_OFS_FLAGS_B, FCX_OFS_FLAGS_B, FCX_OFS_FLAGS_B,
                                 FCX_OFS_FLAGS_B, FCX_OFS_FLAGS_C};
    logic [7:0]  lv_bit [5]  = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04};
    logic [8:0]  rt_in [8]   = '{9'h013, 9'h014, 9'h0C8, 9'h0C9,
                                 9'h109, 9'h10A, 9'h164, 9'h165};
    logic [7:0]  rt_exp [8]  = '{8'h04, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h02};

    fcx_fault_flags #(.RATIO_W(8), .NUM_SWITCH(4)) dut (
        .core_clk(core_clk), .nrst(nrst), .reg_reset(reg_reset), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .batt_ov_cond(batt_ov_cond), .batt_oc_evt(batt_oc_evt),
        .vbat_regulating(vbat_regulating), .ibat_regulating(ibat_regulating),
        .die_ot_cond(die_ot_cond), .out_ov_cond(out_ov_cond), .bypass_mode(bypass_mode),
        .input_ratio(input_ratio), .input_ratio_low_limit(lo_lim),
        .input_ratio_high_limit(hi_lim), .switch_peak_hit(switch_peak_hit),
        .input_present(input_present), .adapter_present(adapter_present),
        .battery_present(battery_present), .host_watchdog_expired(wdog),
        .switching_enabled(switching_enabled), .pin_short_detect(pin_short_detect),
        .charge_operation_sel(charge_operation_sel), .adc_chan_done(adc_chan_done),
        .adc_start(adc_start), .adc_chan(adc_chan), .host_irq_n(host_irq_n));

    fcx_adc_model conv (.core_clk(core_clk), .nrst(nrst), .adc_start(adc_start),
        .adc_chan(adc_chan), .hist_clr(hist_clr), .adc_chan_done(adc_chan_done),
        .chan_hist(chan_hist), .start_cnt(start_cnt));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // A zero mask only performs the clearing read
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        if (m != 8'h00)
            check_val({16'h0000, reg_rdata & m}, {16'h0000, e});
    endtask : rd

    task automatic irq_is(input logic e);
        tick(3);
        #1;
        check_val({23'h0, host_irq_n}, {23'h0, e});
    endtask : irq_is

    task automatic set_sig(input int k, input logic v);
        case (k)
            0: batt_ov_cond <= v;
            1: vbat_regulating <= v;
            2: ibat_regulating <= v;
            3: die_ot_cond <= v;
            4: out_ov_cond <= v;
            5: batt_oc_evt <= v;
            10: pin_short_detect <= v;
            11: wdog <= v;
            12: reg_reset <= v;
            default: switch_peak_hit[k-6] <= v;
        endcase
    endtask : set_sig

    task automatic pulse(input int k);
        tick(1);
        set_sig(k, 1'b1);
        tick(1);
        set_sig(k, 1'b0);
        tick(2);
    endtask : pulse

    task automatic adc_once(input logic [7:0] wd, input logic [23:0] eh, input logic [3:0] ec);
        int n;
        n = 0;
        tick(1);
        hist_clr <= 1'b1;
        tick(1);
        hist_clr <= 1'b0;
        reg_write(FCX_OFS_CTRL, wd);
        do
        begin
            rd(FCX_OFS_CTRL, 8'h00, 8'h00);
            n++;
        end
        while (reg_rdata[FCX_CTRL_RUN] !== 1'b0 && n < 80);
        check_val(chan_hist, eh);
        check_val({20'h0, start_cnt}, {20'h0, ec});
        rd(FCX_OFS_CTRL, 8'hFF, wd & 8'h7F);
        rd(FCX_OFS_FLAGS_C, 8'h02, 8'h02);
        rd(FCX_OFS_FLAGS_C, 8'h02, 8'h00);
    endtask : adc_once

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #200000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        {nrst, reg_reset, reg_wr, reg_rd, hist_clr, reg_addr, reg_wdata} = '0;
        {batt_ov_cond, batt_oc_evt, vbat_regulating, ibat_regulating} = '0;
        {die_ot_cond, out_ov_cond, bypass_mode, battery_present, wdog} = '0;
        {pin_short_detect, switch_peak_hit} = '0;
        {input_present, adapter_present, switching_enabled} = 3'b111;
        input_ratio = 8'h32;
        lo_lim = 8'h0A;
        hi_lim = 8'h64;
        charge_operation_sel = 3'h1;
        tick(5);
        nrst <= 1'b1;
        rd(FCX_OFS_MASK_B, 8'hFF, FCX_RST_MASK);
        rd(FCX_OFS_MASK_C, 8'hFF, FCX_RST_MASK);
        rd(FCX_OFS_CTRL, 8'hFF, FCX_RST_CTRL);
        rd(FCX_OFS_FLAGS_C, 8'hFF, 8'h80);
        rd(FCX_OFS_FLAGS_C, 8'h80, 8'h80);
        irq_is(1'b0);
        rd(8'h20, 8'hFF, FCX_RD_UNMAPPED);
        reg_write(FCX_OFS_MASK_C, 8'h80);
        irq_is(1'b1);
        $display("test reset_and_mask done");
        input_present <= 1'b0;
        tick(3);
        rd(FCX_OFS_FLAGS_C, 8'h88, 8'h88);
        rd(FCX_OFS_FLAGS_C, 8'h88, 8'h08);
        irq_is(1'b0);
        input_present <= 1'b1;
        adapter_present <= 1'b0;
        tick(3);
        rd(FCX_OFS_FLAGS_C, 8'h98, 8'h98);
        rd(FCX_OFS_FLAGS_C, 8'h18, 8'h10);
        input_present <= 1'b0;
        battery_present <= 1'b1;
        tick(3);
        rd(FCX_OFS_FLAGS_C, 8'h40, 8'h00);
        adapter_present <= 1'b1;
        tick(3);
        rd(FCX_OFS_FLAGS_C, 8'h40, 8'h40);
        battery_present <= 1'b0;
        input_present <= 1'b1;
        tick(3);
        rd(FCX_OFS_FLAGS_C, 8'h58, 8'h48);
        rd(FCX_OFS_FLAGS_C, 8'h58, 8'h00);
        irq_is(1'b1);
        $display("test presence done");
        for (int k = 0; k < 5; k++)
        begin
            tick(1);
            set_sig(k, 1'b1);
            tick(3);
            rd(lv_addr[k], lv_bit[k], lv_bit[k]);
            irq_is(1'b0);
            rd(lv_addr[k], lv_bit[k], lv_bit[k]);
            set_sig(k, 1'b0);
            tick(2);
            rd(lv_addr[k], lv_bit[k], lv_bit[k]);
            rd(lv_addr[k], lv_bit[k], 8'h00);
            irq_is(1'b1);
        end
        reg_write(FCX_OFS_MASK_B, 8'h80);
        set_sig(0, 1'b1);
        irq_is(1'b1);
        rd(FCX_OFS_FLAGS_B, 8'h80, 8'h80);
        set_sig(0, 1'b0);
        rd(FCX_OFS_FLAGS_B, 8'h80, 8'h80);
        rd(FCX_OFS_FLAGS_B, 8'h80, 8'h00);
        reg_write(FCX_OFS_MASK_B, 8'h00);
        $display("test level_flags done");
        for (int k = 5; k < 11; k++)
        begin
            pulse(k);
            rd(k == 10 ? FCX_OFS_FLAGS_C : FCX_OFS_FLAGS_B, 8'h41, k == 5 ? 8'h40 : 8'h01);
            rd(k == 10 ? FCX_OFS_FLAGS_C : FCX_OFS_FLAGS_B, 8'h41, 8'h00);
        end
        switching_enabled <= 1'b0;
        pulse(10);
        rd(FCX_OFS_FLAGS_C, 8'h01, 8'h00);
        $display("test event_flags done");
        for (int i = 0; i < 8; i++)
        begin
            tick(1);
            bypass_mode <= rt_in[i][8];
            input_ratio <= rt_in[i][7:0];
            tick(3);
            rd(FCX_OFS_FLAGS_B, 8'h00, 8'h00);
            tick(2);
            rd(FCX_OFS_FLAGS_B, 8'h06, rt_exp[i]);
        end
        input_ratio <= 8'h32;
        tick(3);
        rd(FCX_OFS_FLAGS_B, 8'h00, 8'h00);
        $display("test ratio done");
        adc_once(8'hFE, 24'h000005, 4'h1);
        adc_once(8'hC0, 24'h012345, 4'h6);
        adc_once(8'hEA, 24'h000135, 4'h3);
        charge_operation_sel <= FCX_CHG_OFF;
        adc_once(8'hC0, 24'h000245, 4'h4);
        reg_write(FCX_OFS_CTRL, 8'hBE);
        tick(40);
        rd(FCX_OFS_CTRL, 8'hFF, 8'hBE);
        rd(FCX_OFS_FLAGS_C, 8'h02, 8'h00);
        pulse(11);
        rd(FCX_OFS_CTRL, 8'h80, 8'h00);
        rd(FCX_OFS_FLAGS_C, 8'h20, 8'h20);
        rd(FCX_OFS_FLAGS_C, 8'h20, 8'h00);
        reg_write(FCX_OFS_MASK_B, 8'hFF);
        reg_write(FCX_OFS_CTRL, 8'h3F);
        pulse(12);
        rd(FCX_OFS_MASK_B, 8'hFF, 8'h00);
        rd(FCX_OFS_CTRL, 8'hFF, 8'h00);
        $display("test converter done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
